// ### rtl/eli_encoder.sv
// Error information encoder with APB registers and interrupt.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module eli_encoder
    import eli_pkg::*;
(
    input  wire logic              ref_clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              req_valid_in,
    input  wire eli_req_s          req_in,
    output logic [INFO_W-1:0]      info_out,
    output logic                   info_valid_out,
    output logic                   done_out,
    output logic                   irq_out,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [7:0]        paddr_in,
    input  wire logic [31:0]       pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out
);

    eli_res_s             fmt_res;
    logic                 ctrl_en;
    logic [EV_W-1:0]      int_status;
    logic [EV_W-1:0]      int_mask;
    logic [EV_W-1:0]      next_int_status;
    logic [7:0]           last_code;
    logic                 last_valid;
    logic [INFO_W-1:0]    last_info;
    logic [COUNT_W-1:0]   entry_count;
    logic                 accept;
    logic                 apb_done;
    logic                 apb_wr;
    logic                 apb_rd;
    logic [EV_W-1:0]      events;
    logic [31:0]          next_rdata;
    logic                 next_err;

    eli_info_fmt u_fmt (
        .req_in  (req_in),
        .res_out (fmt_res)
    );

    // Requests while disabled are dropped, not queued
    assign accept   = req_valid_in && ctrl_en;
    assign apb_done = psel_in && penable_in && pready_out;
    assign apb_wr   = apb_done && pwrite_in;
    assign apb_rd   = apb_done && !pwrite_in;

    function automatic logic addr_mapped(input logic [7:0] addr);
        return (addr == ADDR_CTRL) || (addr == ADDR_LAST_CODE) ||
               (addr == ADDR_LAST_INFO) || (addr == ADDR_COUNT) ||
               (addr == ADDR_INT_STATUS) || (addr == ADDR_INT_MASK);
    endfunction

    // Encoded field, registered for the log write path
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            info_out       <= '0;
            info_valid_out <= 1'b0;
            done_out       <= 1'b0;
        end else begin
            done_out <= accept;
            if (accept) begin
                info_out       <= fmt_res.info; // [R1] [R13]
                info_valid_out <= fmt_res.info_valid; // [R12]
            end
        end
    end

    // Snapshot of the last entry for software
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            last_code   <= '0;
            last_valid  <= 1'b0;
            last_info   <= '0;
            entry_count <= '0;
        end else if (accept) begin
            last_code   <= req_in.code;
            last_valid  <= fmt_res.info_valid;
            last_info   <= fmt_res.info;
            entry_count <= entry_count + 1'b1;
        end
    end

    // Control and mask writes
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            ctrl_en  <= CTRL_EN_RST;
            int_mask <= INT_MASK_RST;
        end else if (apb_wr && pstrb_in[0]) begin
            if (paddr_in == ADDR_CTRL) begin
                ctrl_en <= pwdata_in[0];
            end
            if (paddr_in == ADDR_INT_MASK) begin
                int_mask <= pwdata_in[EV_W-1:0];
            end
        end
    end

    // Sticky events; a read clears only the bits it returned, so new events survive
    always_comb begin
        events              = '0;
        events[EV_DONE]     = accept;
        events[EV_UNDEF]    = accept && !fmt_res.info_valid;
        events[EV_DROP]     = req_valid_in && !ctrl_en;
        next_int_status     = int_status;
        if (apb_rd && (paddr_in == ADDR_INT_STATUS)) begin
            next_int_status = int_status & ~prdata_out[EV_W-1:0];
        end
        next_int_status = next_int_status | events;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            int_status <= '0;
            irq_out    <= 1'b0;
        end else begin
            int_status <= next_int_status;
            irq_out    <= |(next_int_status & int_mask);
        end
    end

    // Read data prepared in the setup cycle
    always_comb begin
        next_rdata = '0;
        next_err   = !addr_mapped(paddr_in);
        case (paddr_in)
            ADDR_CTRL: begin
                next_rdata[0] = ctrl_en;
            end
            ADDR_LAST_CODE: begin
                next_rdata[ENTRY_CODE_LO +: 8]   = last_code;
                next_rdata[ENTRY_VALID_POS]      = last_valid;
            end
            ADDR_LAST_INFO: begin
                next_rdata = last_info;
            end
            ADDR_COUNT: begin
                next_rdata[COUNT_W-1:0] = entry_count;
            end
            ADDR_INT_STATUS: begin
                next_rdata[EV_W-1:0] = int_status;
            end
            ADDR_INT_MASK: begin
                next_rdata[EV_W-1:0] = int_mask;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // One wait-free access phase: ready follows every setup cycle
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in && !penable_in;
            if (psel_in && !penable_in) begin
                prdata_out  <= pwrite_in ? 32'h0000_0000 : next_rdata;
                pslverr_out <= next_err;
            end else begin
                prdata_out  <= '0;
                pslverr_out <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence s_req(logic [7:0] c);
        req_valid_in && ctrl_en && (req_in.code == c);
    endsequence

    sequence s_status_read;
        psel_in && !penable_in && !pwrite_in && (paddr_in == ADDR_INT_STATUS)
        ##1 psel_in && penable_in && pready_out;
    endsequence

    a_undef_zero: assert property ( // [R1] [R13]
        (accept && !code_defined(req_in.code)) |=> (info_out == '0) && !info_valid_out && done_out)
        else $error("undefined code left bits set");

    a_flags_mask: assert property ( // [R2]
        s_req(CODE_INV_FLAGS) |=> info_out == $past(req_in.flags_mask))
        else $error("flags bitmask wrong");

    a_handle_fields: assert property ( // [R3]
        s_req(CODE_INV_HANDLE) |=> (info_out[31:20] == '0)
            && (info_out[POS_FIRST] == $past(req_in.first_in_batch))
            && (info_out[POS_CR] == $past(req_in.cr_required))
            && (info_out[HANDLE_W-1:0] == $past(req_in.int_handle)))
        else $error("invalid handle fields wrong");

    a_ci_always: assert property ( // [R4]
        s_req(CODE_INV_HANDLE) |=> info_out[POS_CI] && info_valid_out)
        else $error("interrupt required bit not one");

    a_portal_bit: assert property ( // [R5]
        (accept && code_pf_handle(req_in.code) && req_in.ci_required)
        |=> info_out[POS_PORTAL] == $past(req_in.interrupt_message_store_portal))
        else $error("portal bit wrong");

    a_operand_id: assert property ( // [R6]
        (accept && code_has_operand(req_in.code))
        |=> info_out[POS_OPND_HI:POS_OPND_LO] == $past(req_in.operand_id))
        else $error("operand identifier wrong");

    a_inter_domain_permission_handle_handle: assert property ( // [R7]
        (accept && (req_in.code == CODE_PF_A || req_in.code == CODE_PF_B) && req_in.inter_domain)
        |=> (info_out[28:16] == '0)
            && (info_out[HANDLE_W-1:0] == $past(req_in.inter_domain_permission_handle)))
        else $error("inter-domain handle wrong");

    a_plain_pf_zero: assert property ( // [R8]
        (accept && (req_in.code == CODE_PF_A || req_in.code == CODE_PF_B) && !req_in.inter_domain)
        |=> info_out[28:0] == '0)
        else $error("plain page fault low bits set");

    a_cr_fault: assert property ( // [R9]
        s_req(CODE_PF_CR) |=> info_out[POS_CR] && (info_out[28:20] == '0)
            && (info_out[POS_FIRST] == $past(req_in.first_in_batch)))
        else $error("record page fault fields wrong");

    a_handle_gate: assert property ( // [R10]
        (accept && code_pf_handle(req_in.code) && !req_in.ci_required)
        |=> (info_out[HANDLE_W-1:0] == '0) && !info_out[POS_CI])
        else $error("handle reported without interrupt");

    a_drain_upper: assert property ( // [R11]
        (s_req(CODE_PF_DRAIN) or s_req(CODE_PF_BATCH))
        |=> (info_out[31:19] == '0) && (info_out[POS_CR] == $past(req_in.cr_required)))
        else $error("drain or batch fault fields wrong");

    a_valid_bit: assert property ( // [R12]
        (accept && code_defined(req_in.code)) |=> info_valid_out && last_valid)
        else $error("info valid bit not set");

    a_status_clear: assert property (
        (!req_valid_in ##0 s_status_read ##0 !req_valid_in) |=> (int_status == '0))
        else $error("status not cleared by read");

    a_irq_level: assert property (
        ##1 (irq_out == |($past(next_int_status) & $past(int_mask))))
        else $error("interrupt level wrong");

    sequence s_setup;
        psel_in && !penable_in;
    endsequence

    a_done_pulse: assert property (
        ##1 (done_out == $past(accept)))
        else $error("done pulse wrong");

    a_hold_info: assert property (
        !accept |=> $stable(info_out) && $stable(info_valid_out))
        else $error("encoded field changed without request");

    a_last_entry: assert property (
        accept |=> (last_code == $past(req_in.code)) && (last_info == info_out)
            && (last_valid == info_valid_out))
        else $error("last entry snapshot wrong");

    a_count_step: assert property (
        accept |=> (entry_count == $past(entry_count) + 16'h0001))
        else $error("entry count did not step");

    a_count_hold: assert property (
        !accept |=> $stable(entry_count))
        else $error("entry count moved without request");

    a_done_event: assert property (
        accept |=> int_status[EV_DONE])
        else $error("done event not recorded");

    a_undef_event: assert property (
        (accept && !code_defined(req_in.code)) |=> int_status[EV_UNDEF])
        else $error("undefined code event not recorded");

    a_drop_event: assert property (
        (req_valid_in && !ctrl_en) |=> int_status[EV_DROP] && !done_out)
        else $error("dropped request not recorded");

    a_status_sticky: assert property (
        !(apb_rd && (paddr_in == ADDR_INT_STATUS))
        |=> ((int_status & $past(int_status)) == $past(int_status)))
        else $error("status bit lost without read");

    a_irq_follow: assert property (
        $stable(int_mask)
        |-> (irq_out == |(int_status & int_mask)))
        else $error("interrupt not following status");

    a_ready_pulse: assert property (
        s_setup |=> pready_out)
        else $error("ready missing after setup");

    a_ready_idle: assert property (
        !(psel_in && !penable_in) |=> !pready_out)
        else $error("ready without setup");

    a_rd_idle: assert property (
        !psel_in |=> (prdata_out == '0) && !pslverr_out)
        else $error("read data outside transfer");

    a_write_rdata: assert property (
        (s_setup ##0 pwrite_in) |=> (prdata_out == '0))
        else $error("read data on write");

    a_unmapped_err: assert property (
        (s_setup ##0 !addr_mapped(paddr_in)) |=> pslverr_out && (prdata_out == '0))
        else $error("unmapped address not refused");

    a_mapped_ok: assert property (
        (s_setup ##0 addr_mapped(paddr_in)) |=> !pslverr_out)
        else $error("mapped address refused");

    a_info_read: assert property (
        (s_setup ##0 (!pwrite_in && (paddr_in == ADDR_LAST_INFO)))
        |=> (prdata_out == $past(last_info)))
        else $error("last info read wrong");

    a_status_rdata: assert property (
        (s_setup ##0 (!pwrite_in && (paddr_in == ADDR_INT_STATUS)))
        |=> (prdata_out == {29'h0, $past(int_status)}))
        else $error("status read wrong");

    a_ctrl_write: assert property (
        (apb_wr && pstrb_in[0] && (paddr_in == ADDR_CTRL))
        |=> (ctrl_en == $past(pwdata_in[0])))
        else $error("enable write lost");

    a_mask_write: assert property (
        (apb_wr && pstrb_in[0] && (paddr_in == ADDR_INT_MASK))
        |=> (int_mask == $past(pwdata_in[EV_W-1:0])))
        else $error("mask write lost");

endmodule // eli_encoder
`default_nettype wire

// ### rtl/eli_info_fmt.sv
// Combinational formatter of the 32-bit error information field.
`timescale 1ns/1ns
`default_nettype none
module eli_info_fmt
    import eli_pkg::*;
(
    input  wire eli_req_s req_in,
    output eli_res_s      res_out
);

    always_comb begin
        res_out = '0; // Unused bits stay zero [R13] [R1]
        case (req_in.code)
            CODE_INV_FLAGS: begin
                res_out.info = req_in.flags_mask; // [R2]
            end
            CODE_INV_HANDLE: begin
                res_out.info[POS_FIRST]      = req_in.first_in_batch; // [R3]
                res_out.info[POS_CR]         = req_in.cr_required; // [R3]
                res_out.info[POS_PORTAL]     = req_in.interrupt_message_store_portal; // [R5]
                res_out.info[POS_CI]         = 1'b1; // [R4]
                res_out.info[HANDLE_W-1:0]   = req_in.int_handle; // [R3]
            end
            CODE_PF_A, CODE_PF_B: begin
                res_out.info[POS_OPND_HI:POS_OPND_LO] = req_in.operand_id; // [R6]
                if (req_in.inter_domain) begin
                    res_out.info[HANDLE_W-1:0] = req_in.inter_domain_permission_handle; // [R7]
                end
                // Otherwise 60:32 stay zero [R8]
            end
            CODE_PF_C, CODE_PF_D: begin
                res_out.info[POS_OPND_HI:POS_OPND_LO] = req_in.operand_id; // [R6]
            end
            CODE_PF_CR: begin
                res_out.info[POS_OPND_HI:POS_OPND_LO] = req_in.operand_id; // [R6]
                res_out.info[POS_FIRST] = req_in.first_in_batch; // [R9]
                res_out.info[POS_CR]    = 1'b1; // [R9]
                res_out.info[POS_CI]    = req_in.ci_required;
                // Portal is undefined without interrupt; zero keeps entries stable
                if (req_in.ci_required) begin
                    res_out.info[POS_PORTAL]   = req_in.interrupt_message_store_portal; // [R5]
                    res_out.info[HANDLE_W-1:0] = req_in.int_handle; // [R10]
                end
            end
            CODE_PF_DRAIN, CODE_PF_BATCH: begin
                res_out.info[POS_CR] = req_in.cr_required; // [R11]
                res_out.info[POS_CI] = req_in.ci_required; // [R11]
                if (req_in.ci_required) begin
                    res_out.info[POS_PORTAL]   = req_in.interrupt_message_store_portal; // [R5]
                    res_out.info[HANDLE_W-1:0] = req_in.int_handle; // [R10] [R11]
                end
            end
            default: begin
                if ((req_in.code >= CODE_ID_LO) && (req_in.code <= CODE_ID_HI)) begin
                    res_out.info[HANDLE_W-1:0] = req_in.inter_domain_permission_handle;
                end
            end
        endcase
        res_out.info_valid = code_defined(req_in.code); // [R12]
    end

endmodule // eli_info_fmt
`default_nettype wire

// ### rtl/eli_pkg.sv
// Package for the event log error information encoder.
//
// Functional notes
// R1: Field carries details only for codes with an encoding; otherwise unused.
// R2: Code 0x11 puts the invalid descriptor flags bitmask in 63:32.
// R3: Code 0x19: 63:52 unused, 51 first in batch, 50 record required, 47:32 handle.
// R4: Code 0x19 always reports completion interrupt required (bit 48) as one.
// R5: Bit 49 portal: 0 for the MSI-X portal, 1 for interrupt message store.
// R6: Page fault codes report the faulting operand identifier in bits 63:61.
// R7: Codes 0x03/0x04 inter-domain: 60:48 unused, 47:32 permission handle.
// R8: Codes 0x03/0x04 not inter-domain: bits 60:32 unused.
// R9: Code 0x1a: 60:52 unused, 51 first in batch, 50 always one.
// R10: Page fault handle in 47:32 only when bit 48 is one.
// R11: Codes 0x26/0x27: 63:51 unused, 50 record, 49 portal, 48 interrupt, handle.
// R12: Entry valid bit 7 set when field holds details; flags errors always valid.
// R13: Every unused bit of the field is driven to zero.
package eli_pkg;

    // Error codes with a defined error information encoding
    localparam logic [7:0] CODE_PF_A       = 8'h03;
    localparam logic [7:0] CODE_PF_B       = 8'h04;
    localparam logic [7:0] CODE_PF_C       = 8'h06;
    localparam logic [7:0] CODE_INV_FLAGS  = 8'h11;
    localparam logic [7:0] CODE_INV_HANDLE = 8'h19;
    localparam logic [7:0] CODE_PF_CR      = 8'h1A;
    localparam logic [7:0] CODE_PF_D       = 8'h1F;
    localparam logic [7:0] CODE_PF_DRAIN   = 8'h26;
    localparam logic [7:0] CODE_PF_BATCH   = 8'h27;
    localparam logic [7:0] CODE_ID_LO      = 8'h29;
    localparam logic [7:0] CODE_ID_HI      = 8'h2C;

    // Field positions, relative to bit 32 of the second quadword
    localparam int POS_OPND_HI = 31;
    localparam int POS_OPND_LO = 29;
    localparam int POS_FIRST   = 19;
    localparam int POS_CR      = 18;
    localparam int POS_PORTAL  = 17;
    localparam int POS_CI      = 16;
    localparam int HANDLE_W    = 16;
    localparam int INFO_W      = 32;
    // Valid bit position in the entry's first quadword
    localparam int ENTRY_VALID_POS = 7;
    localparam int ENTRY_CODE_LO   = 8;

    // APB register byte addresses
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_LAST_CODE  = 8'h04;
    localparam logic [7:0] ADDR_LAST_INFO  = 8'h08;
    localparam logic [7:0] ADDR_COUNT      = 8'h0C;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK   = 8'h14;

    localparam logic        CTRL_EN_RST  = 1'b1;
    localparam logic [2:0]  INT_MASK_RST = 3'h0;
    localparam int          EV_DONE      = 0;
    localparam int          EV_UNDEF     = 1;
    localparam int          EV_DROP      = 2;
    localparam int          EV_W         = 3;
    localparam int          COUNT_W      = 16;

    typedef struct packed {
        logic [7:0]          code;
        logic [INFO_W-1:0]   flags_mask;
        logic [2:0]          operand_id;
        logic                inter_domain;
        logic [HANDLE_W-1:0] inter_domain_permission_handle;
        logic                first_in_batch;
        logic                cr_required;
        logic                ci_required;
        logic                interrupt_message_store_portal;
        logic [HANDLE_W-1:0] int_handle;
    } eli_req_s;

    typedef struct packed {
        logic [INFO_W-1:0] info;
        logic              info_valid;
    } eli_res_s;

    function automatic logic code_defined(input logic [7:0] code);
        return (code == CODE_PF_A) || (code == CODE_PF_B) || (code == CODE_PF_C) ||
               (code == CODE_INV_FLAGS) || (code == CODE_INV_HANDLE) ||
               (code == CODE_PF_CR) || (code == CODE_PF_D) ||
               (code == CODE_PF_DRAIN) || (code == CODE_PF_BATCH) ||
               ((code >= CODE_ID_LO) && (code <= CODE_ID_HI));
    endfunction

    function automatic logic code_has_operand(input logic [7:0] code);
        return (code == CODE_PF_A) || (code == CODE_PF_B) || (code == CODE_PF_C) ||
               (code == CODE_PF_CR) || (code == CODE_PF_D);
    endfunction

    function automatic logic code_pf_handle(input logic [7:0] code);
        return (code == CODE_PF_CR) || (code == CODE_PF_DRAIN) || (code == CODE_PF_BATCH);
    endfunction

endpackage

// ### testbench/eli_log_mem.sv
// Event log memory model that records every encoded entry.
`timescale 1ns/1ns
`default_nettype none
module eli_log_mem
    import eli_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              done_in,
    input  wire logic [INFO_W-1:0] info_in,
    input  wire logic              valid_in
);
    // Small ring; the bench only looks at the newest entry
    logic [INFO_W:0] mem [0:255];
    int unsigned     count;
    logic [INFO_W:0] last;

    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            count = 0;
        end else if (done_in === 1'b1) begin
            mem[count[7:0]] = {valid_in, info_in};
            last = {valid_in, info_in};
            count = count + 1;
        end
    end
endmodule // eli_log_mem
`default_nettype wire

// ### testbench/event_log_error_info_encoder_tb_top.sv
// Self-checking bench for the error information encoder.
`timescale 1ns/1ns
`default_nettype none
module event_log_error_info_encoder_tb_top;
    import eli_pkg::*;
    logic ref_clk_in, rst_b_in, req_valid_in, psel, penable, pwrite;
    eli_req_s req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [INFO_W-1:0] info;
    logic info_valid, done, irq, pready, pslverr, er;
    int err_count, n_tests, cyc, acc;
    logic [7:0] tbl [0:12] = '{8'h03, 8'h04, 8'h06, 8'h11, 8'h19, 8'h1A, 8'h1F,
                               8'h26, 8'h27, 8'h29, 8'h2C, 8'h00, 8'h55};

    eli_encoder dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .req_valid_in(req_valid_in), .req_in(req), .info_out(info),
        .info_valid_out(info_valid), .done_out(done), .irq_out(irq), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
    eli_log_mem lm (.clk_in(ref_clk_in), .rst_b_in(rst_b_in), .done_in(done),
        .info_in(info), .valid_in(info_valid));

    always #50 ref_clk_in = ~ref_clk_in;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Whole APB transfer; waits for pready, only the bench timeout ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready wait", 33'h1, 33'(n));
    endtask

    // Expected {valid, field}; unused bits zero, portal zero when undefined
    function automatic logic [32:0] exp_f(input eli_req_s r);
        logic [15:0] h;
        h = r.ci_required ? r.int_handle : 16'h0;
        case (r.code)
            8'h11: return {1'b1, r.flags_mask};
            8'h19: return {1'b1, 12'h0, r.first_in_batch, r.cr_required,
                           r.interrupt_message_store_portal, 1'b1, r.int_handle};
            8'h03, 8'h04: return {1'b1, r.operand_id, 13'h0,
                r.inter_domain ? r.inter_domain_permission_handle : 16'h0};
            8'h06, 8'h1F: return {1'b1, r.operand_id, 29'h0};
            8'h1A: return {1'b1, r.operand_id, 9'h0, r.first_in_batch, 1'b1,
                           r.ci_required & r.interrupt_message_store_portal, r.ci_required, h};
            8'h26, 8'h27: return {1'b1, 13'h0, r.cr_required,
                           r.ci_required & r.interrupt_message_store_portal, r.ci_required, h};
            8'h29, 8'h2A, 8'h2B, 8'h2C: return {1'b1, 16'h0, r.inter_domain_permission_handle};
            default: return 33'h0;
        endcase
    endfunction

    initial begin
        logic [95:0] rnd;
        logic [32:0] pe;
        logic pv, v;
        logic [7:0] lc;
        eli_req_s r;
        ref_clk_in = 0;
        rst_b_in = 0;
        req_valid_in = 0;
        req = '0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(16558));
        repeat (12) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        chk("info after reset", 33'h0, {info_valid, info});
        pv = 0;
        pe = '0;
        // Each of the 13 table codes once, then random back-to-back traffic
        for (int i = 0; i < 200; i++) begin
            rnd = {$urandom, $urandom, $urandom};
            r = rnd[79:0];
            r.code = (i < 13) ? tbl[i] : tbl[$urandom % 13];
            v = (i < 13) || ($urandom % 4 != 0);
            @(posedge ref_clk_in);
            req_valid_in <= v;
            req <= r;
            @(negedge ref_clk_in);
            chk("done", {32'h0, pv}, {32'h0, done});
            if (pv)
                chk("field", pe, {info_valid, info});
            pv = v;
            if (v) begin
                pe = exp_f(r);
                lc = r.code;
                acc++;
            end
        end
        @(posedge ref_clk_in);
        req_valid_in <= 1'b0;
        @(negedge ref_clk_in);
        chk("field last", pe, {info_valid, info});
        $display("encode traffic done");
        apb(0, ADDR_INT_STATUS, 0);
        chk("status", 33'h3, {1'b0, rd});
        chk("irq masked", 33'h0, {32'h0, irq});
        apb(0, ADDR_INT_STATUS, 0);
        chk("status cleared", 33'h0, {1'b0, rd});
        apb(0, ADDR_LAST_CODE, 0);
        chk("last code", {17'h0, lc, pe[32], 7'h0}, {1'b0, rd});
        apb(0, ADDR_COUNT, 0);
        chk("count", {17'h0, acc[15:0]}, {1'b0, rd});
        apb(0, ADDR_LAST_INFO, 0);
        chk("last info", {1'b0, pe[31:0]}, {1'b0, rd});
        chk("log count", 33'(acc), 33'(lm.count));
        chk("log last", pe, lm.last);
        apb(0, 8'h18, 0);
        chk("unmapped err", 33'h1, {32'h0, er});
        $display("register access done");
        apb(1, ADDR_INT_MASK, 32'h4);
        apb(1, ADDR_CTRL, 32'h0);
        apb(0, ADDR_INT_MASK, 0);
        chk("mask", 33'h4, {1'b0, rd});
        apb(0, ADDR_CTRL, 0);
        chk("ctrl", 33'h0, {1'b0, rd});
        @(posedge ref_clk_in);
        req_valid_in <= 1'b1;
        @(posedge ref_clk_in);
        req_valid_in <= 1'b0;
        @(negedge ref_clk_in);
        chk("dropped done", 33'h0, {32'h0, done});
        @(negedge ref_clk_in);
        chk("irq raised", 33'h1, {32'h0, irq});
        apb(0, ADDR_INT_STATUS, 0);
        chk("drop status", 33'h4, {1'b0, rd});
        repeat (2) @(negedge ref_clk_in);
        chk("irq cleared", 33'h0, {32'h0, irq});
        chk("log unchanged", 33'(acc), 33'(lm.count));
        $display("interrupt test done");
        end_sim();
    end
endmodule // event_log_error_info_encoder_tb_top
`default_nettype wire
